// *** include/dual_timer_defs.svh ***
// Constants for the dual timer/counter block: register indices,
// field positions, reset values and timing counts.
// Assumes a 32-bit classic Wishbone slave, byte address = 4 * index.
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

// Register indices
`define IDX_CONTROL    8'h88
`define IDX_MODE       8'h89
`define IDX_TA_LOW     8'h8a
`define IDX_TB_LOW     8'h8b
`define IDX_TA_HIGH    8'h8c
`define IDX_TB_HIGH    8'h8d
`define IDX_IRQ_EN     8'ha8
`define IDX_IRQ_PRIO   8'hb8
`define IDX_EVT_STAT   8'hc0
`define IDX_EVT_MASK   8'hc1

// Reset values
`define RST_CONTROL    8'h00
`define RST_MODE       8'h00
`define RST_COUNT      8'h00
`define RST_IRQ_EN     8'h00
`define RST_IRQ_PRIO   8'h00
`define RST_EVT        2'h0

// Control register fields
`define BIT_RUN0       4
`define BIT_OVF0       5
`define BIT_RUN1       6
`define BIT_OVF1       7
`define CONTROL_MASK   8'hf0

// Mode register: one nibble per timer
`define MODE_TA_LSB    0
`define MODE_TB_LSB    4
`define FLD_CSEL       2
`define FLD_GATE       3

// Enable and priority register fields
`define BIT_GLOBAL_ON  7
`define BIT_TIMER_A    1
`define BIT_TIMER_B    3

// Event status and mask fields
`define EVT_OVF0       0
`define EVT_OVF1       1

// Timing and vectoring
`define TICK_CLKS      12
`define VEC_TIMER_A    8'h0b
`define VEC_TIMER_B    8'h1b
`define NAT_PRIO_A     3'h2
`define NAT_PRIO_B     3'h4

`endif

// *** include/dual_timer_pkg.sv ***
// Types for the dual timer/counter block.
// Assumes dual_timer_defs.svh for all numeric constants.
`default_nettype none
package dual_timer_pkg;

    // Operating mode of one timer
    typedef enum logic [1:0] {
        MODE_PRESCALED = 2'b00,
        MODE_CASCADED  = 2'b01,
        MODE_RELOAD    = 2'b10,
        MODE_SPLIT     = 2'b11
    } timer_mode_e;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] mode;
        logic [7:0] ta_low;
        logic [7:0] ta_high;
        logic [7:0] tb_low;
        logic [7:0] tb_high;
        logic [7:0] irq_en;
        logic [7:0] irq_prio;
        logic [1:0] evt_stat;
        logic [1:0] evt_mask;
        logic       ack;
        logic [7:0] rdata;
        logic       irq;
        logic       req;
        logic [7:0] vector;
        logic       prio;
    } regs_s;

endpackage
`default_nettype wire

// *** rtl/dual_timer_counter.sv ***
// Two 8+8 bit timer/counters with four modes, gating, external
// counting, overflow flags, interrupt forwarding and Wishbone access.
// Assumes a classic Wishbone master on clk_i and a CPU that pulses
// vec_taken_*_i when it branches to a timer's interrupt routine.
//
// Contract
// - Each timer is two separately addressed bytes
// - Mode 0: high byte behind divide-by-32 prescaler
// - Mode 0: flag set on 13-bit rollover
// - Mode 0: upper three low-byte bits ignored
// - Mode 1: bytes cascaded into 16 bits
// - Mode 2: low byte reloads from high byte
// - Mode 3: timer 0 splits, timer 1 holds
// - Mode nibbles: timer 1 high, timer 0 low
// - Gating bit requires gate pin high too
// - Count-select picks pin falling edges
// - Run bits 4 and 6 start timers
// - Overflow sets flag; vector taken clears it
// - Software flag writes act like hardware
// - Forward only with global and timer enable
// - Priority level from priority register bits
// - Vectors 0x0B and 0x1B, natural priorities
// - Timer mode counts every twelve clocks
// - Count pins sampled each clock, falling edge
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "dual_timer_defs.svh"

module dual_timer_counter #(
    parameter int TICK_DIV = `TICK_CLKS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic [9:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    // Count and gate pins
    input  wire logic        cnt_pin_a_i,
    input  wire logic        cnt_pin_b_i,
    input  wire logic        gating_pin_a_i,
    input  wire logic        gating_pin_b_i,
    // CPU interrupt handshake
    input  wire logic        vec_taken_a_i,
    input  wire logic        vec_taken_b_i,
    output logic             irq_req_o,
    output logic      [7:0]  irq_vector_o,
    output logic             irq_prio_o,
    // Event interrupt
    output logic             irq_o
);
    if (TICK_DIV < 2)
    begin : g_bad_tick
        $error("dual_timer_counter: TICK_DIV must be at least 2");
    end

    dual_timer_pkg::regs_s r_reg, r_next;

    logic tick;
    logic gate_a_lvl;
    logic gate_b_lvl;
    logic fall_a;
    logic fall_b;

    // Timer-mode rate of one count per TICK_DIV clocks
    tick_divider #(
        .DIV    (TICK_DIV)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // Pins cross into clk_i; count pins sampled every clock
    pin_sync u_cnt_a (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (cnt_pin_a_i),
        .level_o (),
        .fall_o  (fall_a)
    );
    pin_sync u_cnt_b (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (cnt_pin_b_i),
        .level_o (),
        .fall_o  (fall_b)
    );
    pin_sync u_gate_a (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (gating_pin_a_i),
        .level_o (gate_a_lvl),
        .fall_o  ()
    );
    pin_sync u_gate_b (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (gating_pin_b_i),
        .level_o (gate_b_lvl),
        .fall_o  ()
    );

    // One 8-bit count step: {carry, value}
    function automatic logic [8:0] inc8(input logic [7:0] v);
        return {1'b0, v} + 9'h001;
    endfunction

    // One count of a whole timer in modes 0..2: {ovf, high, low}
    function automatic logic [16:0] step(
        input dual_timer_pkg::timer_mode_e mode,
        input logic [7:0]                  hi,
        input logic [7:0]                  lo
    );
        logic [16:0] res;
        logic [8:0]  c;
        res = {1'b0, hi, lo};
        c   = 9'h000;
        case (mode)
            dual_timer_pkg::MODE_PRESCALED:
            begin
                // Upper three low bits are left alone
                res[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1f)
                begin
                    c = inc8(hi);
                    res[15:8] = c[7:0];
                    res[16] = c[8];
                end
            end
            dual_timer_pkg::MODE_CASCADED:
            begin
                c = inc8(lo);
                res[7:0] = c[7:0];
                if (c[8])
                begin
                    c = inc8(hi);
                    res[15:8] = c[7:0];
                    res[16] = c[8];
                end
            end
            dual_timer_pkg::MODE_RELOAD:
            begin
                c = inc8(lo);
                // High byte stays, low reloads from it
                res[7:0] = c[8] ? hi : c[7:0];
                res[16] = c[8];
            end
            default:
            begin
                res = {1'b0, hi, lo};
            end
        endcase
        return res;
    endfunction

    // Decoded controls
    dual_timer_pkg::timer_mode_e mode_a;
    dual_timer_pkg::timer_mode_e mode_b;
    logic        run_a;
    logic        run_b;
    logic        en_a;
    logic        en_b;
    logic        inc_a;
    logic        inc_b;
    logic        inc_split_hi;
    logic        split;
    logic [16:0] step_a;
    logic [16:0] step_b;
    logic [8:0]  split_lo;
    logic [8:0]  split_hi;
    logic        ovf_a;
    logic        ovf_b;

    // Mode nibbles and run bits
    assign mode_a = dual_timer_pkg::timer_mode_e'(
        r_reg.mode[`MODE_TA_LSB +: 2]);
    assign mode_b = dual_timer_pkg::timer_mode_e'(
        r_reg.mode[`MODE_TB_LSB +: 2]);
    assign run_a  = r_reg.control[`BIT_RUN0];
    assign run_b  = r_reg.control[`BIT_RUN1];
    assign split  = (mode_a == dual_timer_pkg::MODE_SPLIT);

    // Gating: gate pin must be high when the gating bit is set
    assign en_a = run_a & (~r_reg.mode[`MODE_TA_LSB + `FLD_GATE]
                           | gate_a_lvl);
    // Run bit of timer 1 belongs to the split high byte
    assign en_b = (run_b | split)
                & (~r_reg.mode[`MODE_TB_LSB + `FLD_GATE] | gate_b_lvl);

    // Count source: pin edge or internal tick
    assign inc_a = en_a & (r_reg.mode[`MODE_TA_LSB + `FLD_CSEL]
                           ? fall_a : tick);
    // Timer 1 in mode 3 holds its count
    assign inc_b = en_b & (mode_b != dual_timer_pkg::MODE_SPLIT)
                 & (r_reg.mode[`MODE_TB_LSB + `FLD_CSEL]
                    ? fall_b : tick);
    // Split high byte is a pure timer under timer 1 run bit
    assign inc_split_hi = split & run_b & tick;

    assign step_a   = step(mode_a, r_reg.ta_high, r_reg.ta_low);
    assign step_b   = step(mode_b, r_reg.tb_high, r_reg.tb_low);
    assign split_lo = inc8(r_reg.ta_low);
    assign split_hi = inc8(r_reg.ta_high);

    // Overflow events; split high byte takes over timer 1 flag
    assign ovf_a = split ? (inc_a & split_lo[8]) : (inc_a & step_a[16]);
    assign ovf_b = split ? (inc_split_hi & split_hi[8])
                         : (inc_b & step_b[16]);

    // Bus decode
    logic       bus_req;
    logic       bus_wr;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic       req_a;
    logic       req_b;
    logic       pick_b;

    // Classic cycle, one wait state, then ack for one clock
    assign bus_req = cyc_i & stb_i & ~r_reg.ack;
    assign bus_wr  = bus_req & we_i & sel_i[0];
    assign idx     = adr_i[9:2];
    assign wdata   = dat_i[7:0];

    // Next state of the whole block
    always_comb
    begin
        r_next = r_reg;

        // Counting first; a bus write in the same cycle wins below
        if (split)
        begin
            if (inc_a)
                r_next.ta_low = split_lo[7:0];
            if (inc_split_hi)
                r_next.ta_high = split_hi[7:0];
        end
        else if (inc_a)
        begin
            r_next.ta_high = step_a[15:8];
            r_next.ta_low  = step_a[7:0];
        end
        if (inc_b)
        begin
            r_next.tb_high = step_b[15:8];
            r_next.tb_low  = step_b[7:0];
        end

        // Register writes; each timer byte on its own index
        if (bus_wr)
        begin
            case (idx)
                `IDX_CONTROL:
                    // Flag writes behave like hardware ones
                    r_next.control = wdata & `CONTROL_MASK;
                `IDX_MODE:     r_next.mode     = wdata;
                `IDX_TA_LOW:   r_next.ta_low   = wdata;
                `IDX_TA_HIGH:  r_next.ta_high  = wdata;
                `IDX_TB_LOW:   r_next.tb_low   = wdata;
                `IDX_TB_HIGH:  r_next.tb_high  = wdata;
                `IDX_IRQ_EN:   r_next.irq_en   = wdata;
                `IDX_IRQ_PRIO: r_next.irq_prio = wdata;
                `IDX_EVT_STAT:
                    r_next.evt_stat = r_reg.evt_stat & ~wdata[1:0];
                `IDX_EVT_MASK: r_next.evt_mask = wdata[1:0];
                default:       r_next.mode     = r_reg.mode;
            endcase
        end

        // Branch to the routine clears the flag
        if (vec_taken_a_i)
            r_next.control[`BIT_OVF0] = 1'b0;
        if (vec_taken_b_i)
            r_next.control[`BIT_OVF1] = 1'b0;

        // Overflow sets the flag; a set beats any clear
        if (ovf_a)
            r_next.control[`BIT_OVF0] = 1'b1;
        if (ovf_b)
            r_next.control[`BIT_OVF1] = 1'b1;

        // Sticky event bits, set wins over write-one-clear
        if (ovf_a)
            r_next.evt_stat[`EVT_OVF0] = 1'b1;
        if (ovf_b)
            r_next.evt_stat[`EVT_OVF1] = 1'b1;
        r_next.irq = |(r_next.evt_stat & r_next.evt_mask);

        // Read answer, registered with the ack
        r_next.ack   = bus_req;
        r_next.rdata = 8'h00;
        if (bus_req & ~we_i)
        begin
            case (idx)
                `IDX_CONTROL:  r_next.rdata = r_reg.control;
                `IDX_MODE:     r_next.rdata = r_reg.mode;
                `IDX_TA_LOW:   r_next.rdata = r_reg.ta_low;
                `IDX_TA_HIGH:  r_next.rdata = r_reg.ta_high;
                `IDX_TB_LOW:   r_next.rdata = r_reg.tb_low;
                `IDX_TB_HIGH:  r_next.rdata = r_reg.tb_high;
                `IDX_IRQ_EN:   r_next.rdata = r_reg.irq_en;
                `IDX_IRQ_PRIO: r_next.rdata = r_reg.irq_prio;
                `IDX_EVT_STAT: r_next.rdata = {6'h00, r_reg.evt_stat};
                `IDX_EVT_MASK: r_next.rdata = {6'h00, r_reg.evt_mask};
                default:       r_next.rdata = 8'h00;
            endcase
        end

        // Forward only with global and timer enables
        req_a = r_next.control[`BIT_OVF0]
              & r_next.irq_en[`BIT_TIMER_A]
              & r_next.irq_en[`BIT_GLOBAL_ON];
        req_b = r_next.control[`BIT_OVF1]
              & r_next.irq_en[`BIT_TIMER_B]
              & r_next.irq_en[`BIT_GLOBAL_ON];

        // Higher level first, then lower natural number
        if (req_a & req_b)
        begin
            if (r_next.irq_prio[`BIT_TIMER_A]
                != r_next.irq_prio[`BIT_TIMER_B])
                pick_b = r_next.irq_prio[`BIT_TIMER_B];
            else
                pick_b = (`NAT_PRIO_B < `NAT_PRIO_A);
        end
        else
        begin
            pick_b = req_b;
        end

        r_next.req    = req_a | req_b;
        r_next.vector = 8'h00;
        r_next.prio   = 1'b0;
        if (r_next.req)
        begin
            // Vector addresses of the two routines
            r_next.vector = pick_b ? `VEC_TIMER_B : `VEC_TIMER_A;
            r_next.prio   = pick_b ? r_next.irq_prio[`BIT_TIMER_B]
                                   : r_next.irq_prio[`BIT_TIMER_A];
        end
    end

    // State register; count bytes start at zero as a safe choice
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r_reg <= '{
                control:  `RST_CONTROL,
                mode:     `RST_MODE,
                ta_low:   `RST_COUNT,
                ta_high:  `RST_COUNT,
                tb_low:   `RST_COUNT,
                tb_high:  `RST_COUNT,
                irq_en:   `RST_IRQ_EN,
                irq_prio: `RST_IRQ_PRIO,
                evt_stat: `RST_EVT,
                evt_mask: `RST_EVT,
                ack:      1'b0,
                rdata:    8'h00,
                irq:      1'b0,
                req:      1'b0,
                vector:   8'h00,
                prio:     1'b0
            };
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign dat_o        = {24'h000000, r_reg.rdata};
    assign ack_o        = r_reg.ack;
    assign irq_o        = r_reg.irq;
    assign irq_req_o    = r_reg.req;
    assign irq_vector_o = r_reg.vector;
    assign irq_prio_o   = r_reg.prio;
endmodule
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for a pin, with a falling edge pulse.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none

module pin_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin and results
    input  wire logic pin_i,
    output logic      level_o,
    output logic      fall_o
);
    struct packed {
        logic meta;
        logic sync;
        logic prev;
    } st_reg, st_next;

    // First stage feeds only the second one
    always_comb
    begin
        st_next      = st_reg;
        st_next.meta = pin_i;
        st_next.sync = st_reg.meta;
        st_next.prev = st_reg.sync;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign level_o = st_reg.sync;
    assign fall_o  = st_reg.prev & ~st_reg.sync;
endmodule
`default_nettype wire

// *** rtl/tick_divider.sv ***
// Divider making a one-cycle enable pulse every DIV clocks.
// Assumes a single clock domain with synchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "dual_timer_defs.svh"

module tick_divider #(
    parameter int DIV = `TICK_CLKS
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Enable pulse
    output logic      tick_o
);
    localparam int W = $clog2(DIV + 1);

    // A divider below two cannot produce a separate pulse
    if (DIV < 2)
    begin : g_bad_div
        $error("tick_divider: DIV must be at least 2");
    end

    struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } st_reg, st_next;

    // Count down, pulse on the wrap
    always_comb
    begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt == '0)
        begin
            st_next.cnt  = W'(DIV - 1);
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.cnt = st_reg.cnt - W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick_o = st_reg.tick;
endmodule
`default_nettype wire

// *** sim/dual_timer_counter_sva.sv ***
// Checker for the dual timer/counter ports.
// Assumes the bind below attaches it to every top instance.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_sva #(
    parameter int TICK_DIV = 12
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        ack_o,
    input  wire logic [31:0] dat_o,
    input  wire logic        irq_req_o,
    input  wire logic [7:0]  irq_vector_o,
    input  wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A write the slave takes at this edge
    logic wr;
    assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;

    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_next;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not acked next cycle");
    property p_dat_idle;
        !ack_o |-> dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    property p_unmapped;
        cyc_i && stb_i && !we_i && !ack_o && adr_i[9:2] == 8'h00
            |=> dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_reset_out;
        $fell(rst_i) |-> !irq_o && !irq_req_o && !ack_o;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs active after reset");
    property p_vec_legal;
        irq_req_o |-> irq_vector_o == 8'h0b || irq_vector_o == 8'h1b;
    endproperty
    a_vec_legal: assert property (p_vec_legal)
        else $error("bad vector");
    property p_global_off;
        wr && adr_i[9:2] == 8'ha8 && !dat_i[7] |-> ##[1:3] !irq_req_o;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("request with global enable off");
    property p_mask_off;
        wr && adr_i[9:2] == 8'hc1 && dat_i[1:0] == 2'b00
            |-> ##[1:3] !irq_o;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("irq with all masked");
endmodule
`default_nettype wire

bind dual_timer_counter dual_timer_counter_sva #(.TICK_DIV(TICK_DIV)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .dat_o(dat_o), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .irq_o(irq_o));

// *** sim/dual_timer_counter_test.sv ***
// Bench for the dual timer/counter: bus tasks, scenarios, verdict.
// Assumes pin_stim on the pins and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "dual_timer_defs.svh"
module dual_timer_counter_test;
    logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
    logic [9:0]  adr_i;
    logic [31:0] dat_i, dat_o;
    logic [3:0]  sel_i;
    logic        cnt_a, cnt_b, gate_a, gate_b, tk_a, tk_b;
    logic        irq_req_o, irq_prio_o, irq_o;
    logic [7:0]  irq_vector_o, rd;
    int          failures, comparisons, n;

    dual_timer_counter u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .cnt_pin_a_i(cnt_a), .cnt_pin_b_i(cnt_b), .gating_pin_a_i(gate_a),
        .gating_pin_b_i(gate_b), .vec_taken_a_i(tk_a),
        .vec_taken_b_i(tk_b), .irq_req_o(irq_req_o),
        .irq_vector_o(irq_vector_o), .irq_prio_o(irq_prio_o), .irq_o(irq_o));
    pin_stim u_pins (.clk_i(clk_i), .cnt_a_o(cnt_a), .cnt_b_o(cnt_b),
        .gate_a_o(gate_a), .gate_b_o(gate_b));

    // 125 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Range compare; an unknown never passes
    task automatic chk(input logic [7:0] got, lo, hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        comparisons++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask
    // Classic single cycle; held until ack is sampled high
    task automatic bus(input logic [7:0] idx, input logic w,
                       input logic [7:0] d);
        @(posedge clk_i);
        adr_i <= {idx, 2'b00};
        we_i <= w;
        dat_i <= {24'h0, d};
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        // No cycle count assumed; a lost ack is left to the watchdog
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    // Poll a control bit until set, bounded
    task automatic wait_ctl(input int b);
        int k;
        k = 0;
        do
        begin
            bus(`IDX_CONTROL, 1'b0, 8'h00);
            k++;
        end
        while (rd[b] !== 1'b1 && k < 40);
        chk({7'h0, rd[b]}, 8'h01, 8'h01);
    endtask
    task automatic rchk(input logic [7:0] idx, lo, hi);
        bus(idx, 1'b0, 8'h00);
        chk(rd, lo, hi);
    endtask
    task automatic wrap_up;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #(8 * 30000);
        failures++;
        $display("[FAIL] %0t timeout", $time);
        wrap_up();
    end

    initial
    begin
        failures = 0;
        comparisons = 0;
        {we_i, cyc_i, stb_i, tk_a, tk_b} = 5'h00;
        adr_i = 10'h000;
        dat_i = 32'h0;
        sel_i = 4'h1;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped place, separate count bytes
        rchk(`IDX_CONTROL, 8'h00, 8'h00);
        rchk(`IDX_MODE, 8'h00, 8'h00);
        rchk(`IDX_IRQ_EN, 8'h00, 8'h00);
        rchk(`IDX_IRQ_PRIO, 8'h00, 8'h00);
        bus(8'h00, 1'b1, 8'hff);
        rchk(8'h00, 8'h00, 8'h00);
        bus(`IDX_TA_LOW, 1'b1, 8'h5a);
        bus(`IDX_TA_HIGH, 1'b1, 8'ha5);
        rchk(`IDX_TA_LOW, 8'h5a, 8'h5a);
        rchk(`IDX_TA_HIGH, 8'ha5, 8'ha5);
        // Mode 1: 0xfffe wraps after two ticks of twelve clocks
        bus(`IDX_EVT_MASK, 1'b1, 8'h03);
        bus(`IDX_TA_HIGH, 1'b1, 8'hff);
        bus(`IDX_TA_LOW, 1'b1, 8'hfe);
        bus(`IDX_MODE, 1'b1, 8'h01);
        bus(`IDX_CONTROL, 1'b1, 8'h10);
        n = 0;
        while (irq_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(n[7:0], 8'd10, 8'd26);
        bus(`IDX_CONTROL, 1'b1, 8'h20);
        rchk(`IDX_TA_HIGH, 8'h00, 8'h00);
        rchk(`IDX_TA_LOW, 8'h00, 8'h01);
        rchk(`IDX_CONTROL, 8'h20, 8'h20);
        bus(`IDX_EVT_STAT, 1'b1, 8'h01);
        // Software flags, enables, priority, vectors, hardware clear
        bus(`IDX_IRQ_EN, 1'b1, 8'h8a);
        repeat (3) @(posedge clk_i);
        chk(irq_vector_o, 8'h0b, 8'h0b);
        bus(`IDX_CONTROL, 1'b1, 8'ha0);
        bus(`IDX_IRQ_PRIO, 1'b1, 8'h08);
        repeat (3) @(posedge clk_i);
        chk(irq_vector_o, 8'h1b, 8'h1b);
        chk({7'h0, irq_prio_o}, 8'h01, 8'h01);
        bus(`IDX_IRQ_PRIO, 1'b1, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(irq_vector_o, 8'h0b, 8'h0b);
        @(posedge clk_i) tk_a <= 1'b1;
        @(posedge clk_i) tk_a <= 1'b0;
        rchk(`IDX_CONTROL, 8'h80, 8'h80);
        bus(`IDX_IRQ_EN, 1'b1, 8'h0a);
        repeat (3) @(posedge clk_i);
        chk({7'h0, irq_req_o}, 8'h00, 8'h00);
        @(posedge clk_i) tk_b <= 1'b1;
        @(posedge clk_i) tk_b <= 1'b0;
        rchk(`IDX_CONTROL, 8'h00, 8'h00);
        bus(`IDX_IRQ_EN, 1'b1, 8'h00);
        bus(`IDX_CONTROL, 1'b1, 8'h00);
        // Mode 0: low five bits prescale, 0xff/0x1e rolls in two ticks
        bus(`IDX_MODE, 1'b1, 8'h00);
        bus(`IDX_TA_HIGH, 1'b1, 8'hff);
        bus(`IDX_TA_LOW, 1'b1, 8'h1e);
        bus(`IDX_CONTROL, 1'b1, 8'h10);
        wait_ctl(5);
        bus(`IDX_CONTROL, 1'b1, 8'h00);
        rchk(`IDX_TA_HIGH, 8'h00, 8'h00);
        bus(`IDX_TA_LOW, 1'b0, 8'h00);
        chk(rd & 8'h1f, 8'h00, 8'h01);
        // Mode 2: reload from high byte, high unchanged
        bus(`IDX_MODE, 1'b1, 8'h02);
        bus(`IDX_TA_HIGH, 1'b1, 8'hc8);
        bus(`IDX_TA_LOW, 1'b1, 8'hfe);
        bus(`IDX_CONTROL, 1'b1, 8'h10);
        wait_ctl(5);
        bus(`IDX_CONTROL, 1'b1, 8'h00);
        rchk(`IDX_TA_HIGH, 8'hc8, 8'hc8);
        rchk(`IDX_TA_LOW, 8'hc8, 8'hc9);
        // Gated pin counting: closed gate blocks, open gate counts falls
        bus(`IDX_MODE, 1'b1, 8'h0d);
        bus(`IDX_TA_LOW, 1'b1, 8'h00);
        bus(`IDX_CONTROL, 1'b1, 8'h10);
        u_pins.pulse_a(2);
        rchk(`IDX_TA_LOW, 8'h00, 8'h00);
        u_pins.gate_a(1'b1);
        u_pins.pulse_a(3);
        rchk(`IDX_TA_LOW, 8'h03, 8'h03);
        bus(`IDX_CONTROL, 1'b1, 8'h00);
        // Timer 1 from the upper nibble, then split mode
        bus(`IDX_MODE, 1'b1, 8'h10);
        bus(`IDX_TB_HIGH, 1'b1, 8'hff);
        bus(`IDX_TB_LOW, 1'b1, 8'hfe);
        bus(`IDX_CONTROL, 1'b1, 8'h40);
        wait_ctl(7);
        bus(`IDX_CONTROL, 1'b1, 8'h00);
        rchk(`IDX_TB_HIGH, 8'h00, 8'h00);
        bus(`IDX_MODE, 1'b1, 8'h33);
        bus(`IDX_TB_LOW, 1'b1, 8'h55);
        bus(`IDX_TA_HIGH, 1'b1, 8'hff);
        bus(`IDX_CONTROL, 1'b1, 8'h40);
        wait_ctl(7);
        rchk(`IDX_TB_LOW, 8'h55, 8'h55);
        bus(`IDX_EVT_MASK, 1'b1, 8'h00);
        bus(`IDX_EVT_STAT, 1'b1, 8'h03);
        wrap_up();
    end
endmodule
`default_nettype wire

// *** sim/pin_stim.sv ***
// Far side model: count and gate pins of both timers.
// Assumes the bench calls its tasks from the clk_i domain.
`timescale 1ns/1ns
`default_nettype none
module pin_stim (
    // Clock
    input  wire logic clk_i,
    // Pins
    output logic      cnt_a_o,
    output logic      cnt_b_o,
    output logic      gate_a_o,
    output logic      gate_b_o
);
    // Count pins idle high, gates closed
    initial
    begin
        cnt_a_o = 1'b1;
        cnt_b_o = 1'b1;
        gate_a_o = 1'b0;
        gate_b_o = 1'b0;
    end
    // Four-clock phases, so the two-flop sync cannot miss one
    task automatic pulse_a(input int n);
        repeat (n)
        begin
            @(posedge clk_i) cnt_a_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            cnt_a_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask
    // Gate level, held until changed
    task automatic gate_a(input logic v);
        @(posedge clk_i) gate_a_o <= v;
    endtask
endmodule
`default_nettype wire
